// *** bis_sequencer.sv ***
// Purpose: Burner ignition sequencer for a gas hot water boiler
// Assumes: Pins are asynchronous; registers on a plain strobe port
// Notes: Phase timers restart on every state entry
// Behaviour
// - In standby only the power lamp is lit.
// - A heat demand turns the circulator on at once.
// - A self check of two seconds precedes the draft inducer.
// - Proved airflow lights the purge lamp and starts a 15 s pre-purge.
// - Pre-purge end swaps purge lamp for igniter lamp and heats the igniter 20 s.
// - Warm-up end opens the gas valve, lights its lamp and starts a 6 s trial.
// - Two seconds into the trial the igniter and its lamp go off, gas stays on.
// - Flame seen in the last two trial seconds lights the flame lamp and runs the burner.
// - Demand end closes gas and circulator and runs a 30 s post-purge with purge lamp.
// - Post-purge end stops the inducer, darkens the purge lamp and returns to standby.
// - No flame by trial end closes the gas valve and darkens its lamp.
// - An open high limit stops the burner, circulator runs, relight after full purge.
// - The high limit setpoint is held between 100 and 200 degrees F.
// - Any other safety trip stops the burner and it relights once restored.
//
// The register addresses and the strobed register port are this design's own decisions.
module bis_sequencer #(
   parameter int TICK_CYCLES = bis_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   // Field inputs
   input wire logic heat_demand,
   input wire logic airflow_ok,
   input wire logic flame_sense,
   input wire logic high_limit_ok,
   input wire logic safety_ok,
   // Actuators
   output logic circulator,
   output logic inducer,
   output logic igniter,
   output logic gas_valve,
   // Lamps, setpoint and interrupt
   output logic [4:0] lamp,
   output logic [7:0] limit_setpoint,
   output logic irq
);
   bis_pkg::bis_regs_type r;
   bis_pkg::bis_regs_type n;
   logic tick;
   logic dem;
   logic air;
   logic flame;
   logic safe;
   logic active;

   // Synchronised inputs and one-second tick
   assign dem = r.s2[bis_pkg::IN_DEM];
   assign air = r.s2[bis_pkg::IN_AIR];
   assign flame = r.s2[bis_pkg::IN_FLAME];
   assign safe = r.s2[bis_pkg::IN_LIMIT] & r.s2[bis_pkg::IN_SAFE];
   assign tick = (r.div == bis_pkg::bis_div_type'(TICK_CYCLES - 1));
   assign active = r.st inside {bis_pkg::ST_SELFCHK, bis_pkg::ST_AIRWAIT,
      bis_pkg::ST_PREPURGE, bis_pkg::ST_WARMUP, bis_pkg::ST_TRIAL, bis_pkg::ST_RUN};

   // Next state of everything
   always_comb begin
      logic [bis_pkg::NIRQ-1:0] ev;
      ev = '0;
      n = r;
      n.s1 = {safety_ok, high_limit_ok, flame_sense, airflow_ok, heat_demand};
      n.s2 = r.s1;
      // Time base
      n.div = tick ? '0 : r.div + 1'b1;
      if (tick && r.sec != bis_pkg::SEC_MAX) begin
         n.sec = r.sec + 5'h01;
      end
      // Sequence
      unique case (r.st)
         bis_pkg::ST_STANDBY: begin
            if (dem) begin
               n.st = bis_pkg::ST_SELFCHK;
            end
         end
         bis_pkg::ST_SELFCHK: begin
            if (r.sec >= bis_pkg::SELFCHK_S) begin
               n.st = bis_pkg::ST_AIRWAIT;
            end
         end
         bis_pkg::ST_AIRWAIT: begin
            if (air) begin
               n.st = bis_pkg::ST_PREPURGE;
            end
         end
         bis_pkg::ST_PREPURGE: begin
            if (r.sec >= bis_pkg::PREPURGE_S) begin
               n.st = bis_pkg::ST_WARMUP;
            end
         end
         bis_pkg::ST_WARMUP: begin
            if (r.sec >= bis_pkg::WARMUP_S) begin
               n.st = bis_pkg::ST_TRIAL;
            end
         end
         bis_pkg::ST_TRIAL: begin
            if (r.sec >= bis_pkg::FLAME_WIN_S && flame) begin
               n.st = bis_pkg::ST_RUN;
               ev[bis_pkg::IRQ_FLAME] = 1'b1;
            end else if (r.sec >= bis_pkg::TRIAL_S) begin
               n.st = bis_pkg::ST_LOCKOUT;
               ev[bis_pkg::IRQ_LOCK] = 1'b1;
            end
         end
         bis_pkg::ST_RUN: begin
            if (!flame) begin
               n.st = bis_pkg::ST_AIRWAIT;
            end
         end
         bis_pkg::ST_HOLD: begin
            if (!dem) begin
               n.st = bis_pkg::ST_POSTPURGE;
            end else if (safe) begin
               n.st = bis_pkg::ST_AIRWAIT;
            end
         end
         bis_pkg::ST_POSTPURGE: begin
            if (r.sec >= bis_pkg::POSTPURGE_S) begin
               n.st = bis_pkg::ST_STANDBY;
               ev[bis_pkg::IRQ_DONE] = 1'b1;
            end
         end
         bis_pkg::ST_LOCKOUT: begin
            if (!dem) begin
               n.st = bis_pkg::ST_STANDBY;
            end
         end
      endcase
      // Demand end and safety trips override the sequence
      if (active && !dem) begin
         n.st = bis_pkg::ST_POSTPURGE;
         ev = '0;
      end else if (active && !safe) begin
         n.st = bis_pkg::ST_HOLD;
         ev = '0;
         ev[bis_pkg::IRQ_HOLD] = 1'b1;
      end
      // Timer restarts on entry
      if (n.st != r.st) begin
         n.sec = '0;
         n.div = '0;
      end
      // Lamps and all actuators but the circulator follow the new state; the circulator follows demand
      n.circ = dem;
      n.induc = n.st inside {bis_pkg::ST_AIRWAIT, bis_pkg::ST_PREPURGE,
         bis_pkg::ST_WARMUP, bis_pkg::ST_TRIAL, bis_pkg::ST_RUN,
         bis_pkg::ST_POSTPURGE};
      n.ign = (n.st == bis_pkg::ST_WARMUP) ||
         (n.st == bis_pkg::ST_TRIAL && n.sec < bis_pkg::IGN_OFF_S);
      n.gas = n.st inside {bis_pkg::ST_TRIAL, bis_pkg::ST_RUN};
      n.lamp[bis_pkg::LAMP_PWR] = 1'b1;
      n.lamp[bis_pkg::LAMP_PURGE] = n.st inside {bis_pkg::ST_PREPURGE,
         bis_pkg::ST_POSTPURGE};
      n.lamp[bis_pkg::LAMP_IGN] = n.ign;
      n.lamp[bis_pkg::LAMP_GAS] = n.gas;
      n.lamp[bis_pkg::LAMP_FLAME] = (n.st == bis_pkg::ST_RUN);
      // Sticky events, set beats a write-one clear
      if (wr_en && addr == bis_pkg::OFS_IRQ_STAT) begin
         n.istat = (r.istat & ~wdata[bis_pkg::NIRQ-1:0]) | ev;
      end else begin
         n.istat = r.istat | ev;
      end
      if (wr_en && addr == bis_pkg::OFS_IRQ_MASK) begin
         n.imask = wdata[bis_pkg::NIRQ-1:0];
      end
      // Setpoint write clamped to the allowed span
      if (wr_en && addr == bis_pkg::OFS_SETP) begin
         if (wdata < {24'h000000, bis_pkg::SETP_MIN_F}) begin
            n.setp = bis_pkg::SETP_MIN_F;
         end else if (wdata > {24'h000000, bis_pkg::SETP_MAX_F}) begin
            n.setp = bis_pkg::SETP_MAX_F;
         end else begin
            n.setp = wdata[7:0];
         end
      end
      // Read data stands only the cycle after the strobe
      n.rdata = '0;
      if (rd_en) begin
         unique case (addr)
            bis_pkg::OFS_STATUS: n.rdata = {17'h00000, r.lamp, r.st};
            bis_pkg::OFS_IRQ_STAT: n.rdata = {28'h0000000, r.istat};
            bis_pkg::OFS_IRQ_MASK: n.rdata = {28'h0000000, r.imask};
            bis_pkg::OFS_SETP: n.rdata = {24'h000000, r.setp};
            default: n.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
         r.st <= bis_pkg::ST_STANDBY;
         r.lamp <= bis_pkg::LAMP_RST;
         r.setp <= bis_pkg::SETP_RST_F;
      end else begin
         r <= n;
      end
   end

   // Outputs
   assign rdata = r.rdata;
   assign circulator = r.circ;
   assign inducer = r.induc;
   assign igniter = r.ign;
   assign gas_valve = r.gas;
   assign lamp = r.lamp;
   assign limit_setpoint = r.setp;
   assign irq = |(r.istat & r.imask);

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_standby;
      r.st == bis_pkg::ST_STANDBY |-> lamp == 5'h01 && !gas_valve && !inducer;
   endproperty
   a_standby: assert property (p_standby) else $error("standby lamps wrong");

   property p_circ;
      $rose(dem) |=> circulator;
   endproperty
   a_circ: assert property (p_circ) else $error("circulator late");

   property p_selfchk;
      r.st == bis_pkg::ST_SELFCHK |-> !inducer ##0 r.sec <= bis_pkg::SELFCHK_S;
   endproperty
   a_selfchk: assert property (p_selfchk) else $error("self check wrong");

   property p_prepurge;
      $rose(r.st == bis_pkg::ST_PREPURGE) |-> $past(air) && inducer && lamp[1];
   endproperty
   a_prepurge: assert property (p_prepurge) else $error("pre-purge wrong");

   property p_warmup;
      r.st == bis_pkg::ST_WARMUP |-> igniter && lamp[2] && !lamp[1] && !gas_valve;
   endproperty
   a_warmup: assert property (p_warmup) else $error("warm-up wrong");

   property p_trial;
      $rose(r.st == bis_pkg::ST_TRIAL) |-> gas_valve && lamp[3] && igniter;
   endproperty
   a_trial: assert property (p_trial) else $error("trial start wrong");

   property p_ign_off;
      r.st == bis_pkg::ST_TRIAL && r.sec >= bis_pkg::IGN_OFF_S |-> !igniter && !lamp[2] && gas_valve;
   endproperty
   a_ign_off: assert property (p_ign_off) else $error("igniter not off");

   property p_run;
      $rose(r.st == bis_pkg::ST_RUN) |-> $past(flame) && $past(r.sec) >= bis_pkg::FLAME_WIN_S && gas_valve && lamp[4];
   endproperty
   a_run: assert property (p_run) else $error("run entry wrong");

   property p_post;
      r.st == bis_pkg::ST_POSTPURGE |-> !gas_valve && !lamp[3] && inducer && lamp[1] && r.sec <= bis_pkg::POSTPURGE_S;
   endproperty
   a_post: assert property (p_post) else $error("post-purge wrong");

   property p_done;
      $fell(r.st == bis_pkg::ST_POSTPURGE) && r.st == bis_pkg::ST_STANDBY |-> !inducer && !lamp[1];
   endproperty
   a_done: assert property (p_done) else $error("post-purge end wrong");

   property p_lock;
      r.st == bis_pkg::ST_LOCKOUT && dem |=> r.st == bis_pkg::ST_LOCKOUT && !gas_valve && !lamp[3];
   endproperty
   a_lock: assert property (p_lock) else $error("lockout left");

   property p_hold;
      r.st == bis_pkg::ST_HOLD |-> !gas_valve && !igniter && circulator;
   endproperty
   a_hold: assert property (p_hold) else $error("hold fires burner");

   property p_setp;
      limit_setpoint >= bis_pkg::SETP_MIN_F && limit_setpoint <= bis_pkg::SETP_MAX_F;
   endproperty
   a_setp: assert property (p_setp) else $error("setpoint out of span");

   property p_entry;
      $changed(r.st) |-> r.sec == 5'h00 && r.div == '0;
   endproperty
   a_entry: assert property (p_entry) else $error("timer not restarted");

   property p_tick;
      r.div <= bis_pkg::bis_div_type'(TICK_CYCLES - 1);
   endproperty
   a_tick: assert property (p_tick) else $error("time base overrun");

   // Main scenarios
   c_run: cover property (r.st == bis_pkg::ST_RUN);
   c_lock: cover property (r.st == bis_pkg::ST_LOCKOUT);
   c_hold: cover property (r.st == bis_pkg::ST_HOLD);
   c_done: cover property ($fell(r.st == bis_pkg::ST_POSTPURGE));
   c_flame_loss: cover property (r.st == bis_pkg::ST_RUN && !flame);
endmodule

// *** bis_pkg.sv ***
// Purpose: Shared constants and types of the burner ignition sequencer
// Assumes: 25 MHz ref_clk, one-second phase tick
// Notes: All phase times are whole seconds
package bis_pkg;
   // Clock and time base
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_S = 1;
   localparam int SEC_CYCLES = TICK_S * CLK_HZ;
   localparam int DIV_W = 25;
   typedef logic [DIV_W-1:0] bis_div_type;
   // Phase lengths in seconds
   localparam logic [4:0] SELFCHK_S = 5'h02;
   localparam logic [4:0] PREPURGE_S = 5'h0f;
   localparam logic [4:0] WARMUP_S = 5'h14;
   localparam logic [4:0] TRIAL_S = 5'h06;
   localparam logic [4:0] IGN_OFF_S = 5'h02;
   localparam logic [4:0] FLAME_WIN_S = 5'h04;
   localparam logic [4:0] POSTPURGE_S = 5'h1e;
   localparam logic [4:0] SEC_MAX = 5'h1f;
   // High limit setpoint in degrees F
   localparam logic [7:0] SETP_MIN_F = 8'h64;
   localparam logic [7:0] SETP_MAX_F = 8'hc8;
   localparam logic [7:0] SETP_RST_F = 8'hb4;
   // Register byte offsets
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
   localparam logic [3:0] OFS_SETP = 4'hc;
   // Interrupt bits
   localparam int NIRQ = 4;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_HOLD = 1;
   localparam int IRQ_FLAME = 2;
   localparam int IRQ_DONE = 3;
   // Lamp bits and synchronised input bits
   localparam int LAMP_PWR = 0;
   localparam int LAMP_PURGE = 1;
   localparam int LAMP_IGN = 2;
   localparam int LAMP_GAS = 3;
   localparam int LAMP_FLAME = 4;
   localparam logic [4:0] LAMP_RST = 5'h01;
   localparam int IN_DEM = 0;
   localparam int IN_AIR = 1;
   localparam int IN_FLAME = 2;
   localparam int IN_LIMIT = 3;
   localparam int IN_SAFE = 4;
   // Sequencer states
   typedef enum logic [9:0] {
      ST_STANDBY = 10'h001,
      ST_SELFCHK = 10'h002,
      ST_AIRWAIT = 10'h004,
      ST_PREPURGE = 10'h008,
      ST_WARMUP = 10'h010,
      ST_TRIAL = 10'h020,
      ST_RUN = 10'h040,
      ST_HOLD = 10'h080,
      ST_POSTPURGE = 10'h100,
      ST_LOCKOUT = 10'h200
   } bis_state_type;
   // Whole state of the sequencer
   typedef struct packed {
      bis_state_type st;
      logic [4:0] sec;
      bis_div_type div;
      logic [4:0] s1;
      logic [4:0] s2;
      logic circ;
      logic induc;
      logic ign;
      logic gas;
      logic [4:0] lamp;
      logic [NIRQ-1:0] istat;
      logic [NIRQ-1:0] imask;
      logic [7:0] setp;
      logic [31:0] rdata;
   } bis_regs_type;
endpackage

// *** bis_field_model.sv ***
// Purpose: Field side of the sequencer: air switch and flame sensor
// Assumes: Switch opens and flame dies as soon as their cause stops
// Notes: Delays are in ref_clk cycles
module bis_field_model #(
   parameter int AIR_DLY = 3,
   parameter int FLAME_DLY = 6
) (
   // Clock
   input wire logic ref_clk,
   // Actuators seen
   input wire logic inducer,
   input wire logic gas_valve,
   input wire logic flame_en,
   // Sensors driven
   output logic airflow_ok,
   output logic flame_sense
);
   timeunit 1ns;
   timeprecision 1ps;
   int acnt = 0;
   int fcnt = 0;
   // Air proves after spin-up, flame after gas opens
   always @(posedge ref_clk) begin
      if (!inducer) begin
         acnt <= 0;
         airflow_ok <= 1'b0;
      end else if (acnt == AIR_DLY) airflow_ok <= 1'b1;
      else acnt <= acnt + 1;
      if (!gas_valve || !flame_en) begin
         fcnt <= 0;
         flame_sense <= 1'b0;
      end else if (fcnt == FLAME_DLY) flame_sense <= 1'b1;
      else fcnt <= fcnt + 1;
   end
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench of the burner sequencer
// Assumes: One-second tick shortened to four cycles
// Notes: States are followed by polling the status register
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic heat_demand = 1'b0;
   logic high_limit_ok = 1'b1;
   logic safety_ok = 1'b1;
   logic flame_en = 1'b1;
   logic [31:0] rdata;
   logic airflow_ok, flame_sense, circulator, inducer, igniter, gas_valve, irq;
   logic [4:0] lamp;
   logic [7:0] limit_setpoint;
   int fail_count = 0;
   int total_checks = 0;
   int n;
   logic [31:0] d;
   logic [31:0] sw[3] = '{32'h32, 32'h0001_0096, 32'h96};
   logic [31:0] se[3] = '{32'h64, 32'hc8, 32'h96};
   wire [9:0] obs = {irq, lamp, gas_valve, igniter, inducer, circulator};
   bis_sequencer #(.TICK_CYCLES(TK)) bis_sequencer_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .heat_demand(heat_demand),
      .airflow_ok(airflow_ok), .flame_sense(flame_sense), .high_limit_ok(high_limit_ok),
      .safety_ok(safety_ok), .circulator(circulator), .inducer(inducer), .igniter(igniter),
      .gas_valve(gas_valve), .lamp(lamp), .limit_setpoint(limit_setpoint), .irq(irq));
   bis_field_model bis_field_model_i (.ref_clk(ref_clk), .inducer(inducer), .gas_valve(gas_valve),
      .flame_en(flame_en), .airflow_ok(airflow_ok), .flame_sense(flame_sense));
   // Clock
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Compare and report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   // Read strobe, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   // Poll status until the given state shows
   task automatic wst(input logic [9:0] s);
      logic [31:0] v;
      for (int i = 0; i < 200; i++) begin
         rd(bis_pkg::OFS_STATUS, v);
         if (v[9:0] === s) return;
      end
      chk("state wait", {22'h0, s}, v);
      tally_and_finish();
   endtask
   // Count cycles until an observed output goes high
   task automatic wob(input int b, output int c);
      for (c = 0; c < 300; c++) begin
         if (obs[b] === 1'b1) return;
         @(posedge ref_clk);
         #1;
      end
      chk("output wait", b, 32'hffff);
      tally_and_finish();
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1 chk("standby lamp", 5'h01, lamp);
      chk("standby outputs", 5'h0, {irq, gas_valve, igniter, inducer, circulator});
      rd(bis_pkg::OFS_SETP, d);
      chk("setpoint reset", 32'hb4, d);
      for (int i = 0; i < 3; i++) begin
         wr(bis_pkg::OFS_SETP, sw[i]);
         rd(bis_pkg::OFS_SETP, d);
         chk("setpoint", se[i], d);
         chk("setpoint pin", se[i], {24'h000000, limit_setpoint});
      end
      rd(4'h2, d);
      chk("unmapped", 32'h0, d);
      wr(bis_pkg::OFS_IRQ_MASK, 32'hf);
      rd(bis_pkg::OFS_IRQ_MASK, d);
      chk("mask", 32'hf, d);
      @(posedge ref_clk);
      heat_demand <= 1'b1;
      #1;
      wob(0, n);
      chk("circulator delay", 1'b1, n <= 4);
      chk("inducer in self check", 1'b0, inducer);
      wob(1, n);
      chk("self check length", 1'b1, n >= 7 && n <= 11);
      wob(5, n);
      chk("prepurge lamp", 5'h03, lamp);
      wob(6, n);
      chk("prepurge length", 1'b1, n >= 15 * TK - 1 && n <= 15 * TK + 3);
      chk("warmup", 7'h17, {lamp, igniter, inducer});
      wob(3, n);
      chk("warmup length", 1'b1, n >= 20 * TK - 1 && n <= 20 * TK + 3);
      chk("trial lamp", 5'h0d, lamp);
      repeat (10) @(posedge ref_clk);
      #1 chk("igniter off", 7'h25, {lamp, igniter, gas_valve});
      wob(8, n);
      chk("run", 8'hcb, {lamp, igniter, gas_valve, irq});
      rd(bis_pkg::OFS_IRQ_STAT, d);
      chk("flame event", 32'h4, d);
      wr(bis_pkg::OFS_IRQ_STAT, 32'h4);
      #1 chk("irq cleared", 1'b0, irq);
      for (int k = 0; k < 2; k++) begin
         if (k == 0) high_limit_ok <= 1'b0;
         else safety_ok <= 1'b0;
         wst(bis_pkg::ST_HOLD);
         chk("hold", 3'h1, {gas_valve, igniter, circulator});
         high_limit_ok <= 1'b1;
         safety_ok <= 1'b1;
         wst(bis_pkg::ST_PREPURGE);
         wst(bis_pkg::ST_RUN);
      end
      // Flame loss while running relights through a fresh purge
      flame_en <= 1'b0;
      wst(bis_pkg::ST_PREPURGE);
      chk("relight purge", 2'h0, {gas_valve, igniter});
      flame_en <= 1'b1;
      wst(bis_pkg::ST_RUN);
      wr(bis_pkg::OFS_IRQ_STAT, 32'hf);
      heat_demand <= 1'b0;
      wst(bis_pkg::ST_POSTPURGE);
      chk("postpurge", 8'h19, {lamp, gas_valve, circulator, inducer});
      wst(bis_pkg::ST_STANDBY);
      chk("back to standby", 6'h02, {lamp, inducer});
      rd(bis_pkg::OFS_IRQ_STAT, d);
      chk("done event", 32'h8, d);
      wr(bis_pkg::OFS_IRQ_STAT, 32'hf);
      wr(bis_pkg::OFS_IRQ_MASK, 32'he);
      flame_en <= 1'b0;
      heat_demand <= 1'b1;
      wst(bis_pkg::ST_TRIAL);
      wst(bis_pkg::ST_LOCKOUT);
      chk("lockout", 6'h02, {lamp, gas_valve});
      repeat (40) @(posedge ref_clk);
      rd(bis_pkg::OFS_STATUS, d);
      chk("lockout held", 11'h200, {gas_valve, d[9:0]});
      rd(bis_pkg::OFS_IRQ_STAT, d);
      chk("lockout event", 32'h1, d);
      chk("masked irq", 1'b0, irq);
      heat_demand <= 1'b0;
      wst(bis_pkg::ST_STANDBY);
      tally_and_finish();
   end
endmodule
